// [core/arpf_device.sv]
// amplifier reset, power-down, fade and fault control with register target
// Function
// - hardware reset low loads register defaults
// - leave reset on 256th clock after release
// - power-down fades out, then stages/clocks/bias off
// - power-down refuses writes, keeps register contents
// - early power-down release fades back in
// - over-temperature stops stages until cooled and the latched fault is cleared
// - thermal or short latches fault output low
// - fault clears by reset, power-down or mute
// - supply undervoltage halts stages and processing
// - start muted until host un-mutes
// - defaults alone run clocks, stages and processing, but audio stays muted until the host writes REG_SC3
// - frame ratio 1024/512/256 per rate
// - carrier is master clock divided by 128
// - device is bus target only
// - host frames transfers with start and stop
// - data sampled on rising serial clock
// - acknowledge own address with select pin
// - byte after address is sub-address
// - bytes are eight bits msb first
// - single and multi byte reads and writes
// - master mute plus three channel mutes
`timescale 1ns/1ns
module arpf_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // link to host
  arpf_if.device bus,
  // analog indicators and strap
  input wire logic addr_sel_i,
  input wire logic temp_hot_i,
  input wire logic temp_cool_i,
  input wire logic short_det_i,
  input wire logic supply_low_i,
  input wire logic supply_ok_i,
  // power and audio controls
  output logic out_stage_en_o,
  output logic dig_clk_en_o,
  output logic analog_bias_en_o,
  output logic proc_run_o,
  output logic in_reset_o,
  output logic carrier_tick_o,
  output logic frame_tick_o,
  output logic [7:0] volume_o,
  output logic master_mute_o,
  output logic [2:0] ch_mute_o
);
  import arpf_pkg::*;

  typedef enum logic [2:0] {
    D_RESET, D_NORMAL, D_FADE_OUT, D_PWRDN, D_FADE_IN
  } arpf_dst_e;

  typedef struct packed {
    arpf_dst_e st;
    logic [7:0] rcnt;
    logic [4:0] fcnt;
    logic [NUM_REGS-1:0][7:0] regs;
    logic boot_mute;
    logic [6:0] div_c;
    logic [9:0] div_f;
    logic [ANA_N-1:0] sy1;
    logic [ANA_N-1:0] sy2;
    logic [ANA_N-1:0] sy3;
    logic [ANA_N-1:0] filt;
    logic therm;
    logic uv;
    logic fault;
    logic out_en;
    logic clk_en;
    logic bias_en;
    logic run;
    logic in_rst;
    logic car_tick;
    logic frm_tick;
    logic [7:0] vol;
    logic mute;
    logic [2:0] chm;
  } arpf_dev_s;

  arpf_dev_s s;
  arpf_dev_s next_s;
  logic tgt_wr;
  logic [7:0] tgt_wr_addr;
  logic [7:0] tgt_wr_data;
  logic [7:0] tgt_rd_addr;
  logic [7:0] rd_data;
  logic wr_ok;

  function automatic arpf_dev_s init_state();
    arpf_dev_s r;
    r = '0;
    r.st = D_RESET;
    r.boot_mute = 1'b1;
    r.vol = VOL_NEG_INF;
    r.mute = 1'b1;
    r.fcnt = 5'(FADE_FRAMES);
    for (int i = 0; i < NUM_REGS; i++) begin
      r.regs[i] = reg_default(i);
    end
    init_state = r;
  endfunction

  function automatic logic [9:0] frame_last(input logic [1:0] fs);
    case (fs)
      2'h0: frame_last = 10'(RATIO_FS48 - 1);
      2'h1: frame_last = 10'(RATIO_FS96 - 1);
      default: frame_last = 10'(RATIO_FS192 - 1);
    endcase
  endfunction

  function automatic logic [7:0] fade_vol(input logic [7:0] mv,
                                          input logic [4:0] cnt);
    logic [12:0] sum;
    sum = 13'(mv) + 13'(cnt) * 13'(FADE_STEP);
    if (cnt >= 5'(FADE_FRAMES) || sum >= 13'(VOL_NEG_INF)) begin
      fade_vol = VOL_NEG_INF;
    end else begin
      fade_vol = sum[7:0];
    end
  endfunction

  // ****************************************
  // register target
  // ****************************************
  assign wr_ok = s.st != D_PWRDN && s.st != D_RESET;
  assign rd_data = (tgt_rd_addr < 8'(NUM_REGS)) ? s.regs[tgt_rd_addr] : 8'h00;

  arpf_i2c_target arpf_i2c_target_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i && bus.hw_reset_in),
    .scl_i(bus.scl),
    .sda_i(bus.sda),
    .addr_sel_i(addr_sel_i),
    .sda_oe_o(bus.dev_sda_oe),
    .wr_ok_i(wr_ok),
    .rd_data_i(rd_data),
    .wr_en_o(tgt_wr),
    .wr_addr_o(tgt_wr_addr),
    .wr_data_o(tgt_wr_data),
    .rd_addr_o(tgt_rd_addr)
  );

  // ****************************************
  // control state
  // ****************************************
  always_comb begin
    logic fade_req;
    logic mreg;
    fade_req = 1'b0;
    mreg = 1'b0;
    next_s = s;
    next_s.car_tick = 1'b0;
    next_s.frm_tick = 1'b0;
    next_s.sy1 = {supply_ok_i, supply_low_i, short_det_i, temp_cool_i,
                  temp_hot_i};
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    for (int i = 0; i < ANA_N; i++) begin
      if (s.sy2[i] == s.sy3[i]) begin
        next_s.filt[i] = s.sy2[i];
      end
    end
    if (!rst_b_i || !bus.hw_reset_in) begin
      next_s = init_state();
    end else begin
      // clock dividers stop while digital clocks are gated
      if (s.clk_en) begin
        next_s.div_c = s.div_c + 7'h1;
        next_s.car_tick = s.div_c == 7'(CARRIER_DIV - 1);
        if (s.div_f >= frame_last(s.regs[REG_SC2][FS_LSB+:2])) begin
          next_s.div_f = 10'h000;
          next_s.frm_tick = 1'b1;
        end else begin
          next_s.div_f = s.div_f + 10'h001;
        end
      end
      if (tgt_wr && wr_ok && tgt_wr_addr < 8'(NUM_REGS)) begin
        next_s.regs[tgt_wr_addr] = tgt_wr_data;
        if (tgt_wr_addr == REG_SC3) begin
          next_s.boot_mute = 1'b0;
        end
      end
      mreg = s.regs[REG_SC3][MUTE_POS];
      if (s.filt[ANA_HOT]) begin
        next_s.therm = 1'b1;
      end else if (s.filt[ANA_COOL]) begin
        next_s.therm = 1'b0;
      end
      if (s.filt[ANA_UVLO]) begin
        next_s.uv = 1'b1;
      end else if (s.filt[ANA_UVOK]) begin
        next_s.uv = 1'b0;
      end
      if (s.filt[ANA_HOT] || s.filt[ANA_SHORT]) begin
        next_s.fault = 1'b1;
      end else if (!s.therm && (!bus.power_down_in || mreg)) begin
        next_s.fault = 1'b0;
      end
      fade_req = !bus.power_down_in || mreg || s.boot_mute;
      case (s.st)
        D_RESET: begin
          next_s.rcnt = s.rcnt + 8'h01;
          if (s.rcnt == 8'(RST_EXIT_CYC - 1)) begin
            next_s.st = D_NORMAL;
          end
        end
        D_NORMAL: begin
          if (fade_req) begin
            next_s.st = D_FADE_OUT;
          end
        end
        D_FADE_OUT: begin
          if (!fade_req) begin
            next_s.st = D_FADE_IN;
          end else if (s.fcnt == 5'(FADE_FRAMES)) begin
            if (!bus.power_down_in) begin
              next_s.st = D_PWRDN;
            end
          end else if (s.frm_tick) begin
            next_s.fcnt = s.fcnt + 5'h01;
          end
        end
        D_PWRDN: begin
          if (bus.power_down_in) begin
            next_s.st = D_FADE_IN;
          end
        end
        D_FADE_IN: begin
          if (fade_req) begin
            next_s.st = D_FADE_OUT;
          end else if (s.fcnt == 5'h00) begin
            next_s.st = D_NORMAL;
          end else if (s.frm_tick) begin
            next_s.fcnt = s.fcnt - 5'h01;
          end
        end
        default: begin
          next_s.st = D_RESET;
        end
      endcase
      next_s.clk_en = s.st != D_PWRDN;
      next_s.bias_en = s.st != D_PWRDN;
      next_s.in_rst = s.st == D_RESET;
      next_s.run = s.st != D_PWRDN && s.st != D_RESET && !s.uv;
      next_s.out_en = s.st != D_PWRDN && s.st != D_RESET && !s.therm
                      && !s.fault && !s.uv;
      next_s.mute = mreg || s.boot_mute;
      next_s.chm = s.regs[REG_SC3][CHM_LSB+:3] | {3{next_s.mute}};
      next_s.vol = fade_vol(s.regs[REG_MVOL], s.fcnt);
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign bus.fault_oe = s.fault;
  assign out_stage_en_o = s.out_en;
  assign dig_clk_en_o = s.clk_en;
  assign analog_bias_en_o = s.bias_en;
  assign proc_run_o = s.run;
  assign in_reset_o = s.in_rst;
  assign carrier_tick_o = s.car_tick;
  assign frame_tick_o = s.frm_tick;
  assign volume_o = s.vol;
  assign master_mute_o = s.mute;
  assign ch_mute_o = s.chm;
endmodule

// [core/arpf_pkg.sv]
// constants and helpers shared by both ends of the amplifier control link
package arpf_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_EXIT_CYC = 256;
  localparam int CARRIER_DIV = 128;
  localparam int RATIO_FS48 = 1024;
  localparam int RATIO_FS96 = 512;
  localparam int RATIO_FS192 = 256;
  localparam int FADE_FRAMES = 16;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // volume and addressing
  // ****************************************
  localparam logic [7:0] FADE_STEP = 8'h10;
  localparam logic [7:0] VOL_NEG_INF = 8'he7;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h30;
  localparam int ADDR_SEL_POS = 2;

  // ****************************************
  // register map
  // ****************************************
  localparam int NUM_REGS = 44;
  localparam logic [7:0] REG_SC2 = 8'h01;
  localparam logic [7:0] REG_SC3 = 8'h02;
  localparam logic [7:0] REG_MVOL = 8'h03;
  localparam int FS_LSB = 4;
  localparam int MUTE_POS = 3;
  localparam int CHM_LSB = 0;

  // ****************************************
  // analog indicator bit positions
  // ****************************************
  localparam int ANA_HOT = 0;
  localparam int ANA_COOL = 1;
  localparam int ANA_SHORT = 2;
  localparam int ANA_UVLO = 3;
  localparam int ANA_UVOK = 4;
  localparam int ANA_N = 5;

  function automatic logic [6:0] dev_addr(input logic sel);
    dev_addr = DEV_ADDR_BASE | 7'({sel, 2'h0});
  endfunction

  function automatic logic [7:0] reg_default(input int idx);
    case (idx)
      3: reg_default = 8'h18;
      4, 5, 6: reg_default = 8'h14;
      7, 8, 11, 12: reg_default = 8'h10;
      10: reg_default = 8'h90;
      14: reg_default = 8'h6a;
      17: reg_default = 8'h32;
      18: reg_default = 8'h81;
      42: reg_default = 8'h0d;
      43: reg_default = 8'h3f;
      default: reg_default = 8'h00;
    endcase
  endfunction

endpackage

// [core/arpf_if.sv]
// pin-level link between the host controller and the amplifier control
`timescale 1ns/1ns
interface arpf_if;
  logic scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic fault_oe;
  logic hw_reset_in;
  logic power_down_in;
  logic scl;
  logic sda;
  logic fault_out;

  // open-drain wires: any enable pulls the line low
  assign scl = ~scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  assign fault_out = ~fault_oe;

  modport host (
    output scl_oe, host_sda_oe, hw_reset_in, power_down_in,
    input scl, sda, fault_out
  );
  modport device (
    output dev_sda_oe, fault_oe,
    input scl, sda, hw_reset_in, power_down_in
  );
endinterface

// [core/arpf_i2c_target.sv]
// two-wire bus target with sub-address pointer for the amplifier registers
`timescale 1ns/1ns
module arpf_i2c_target (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_sel_i,
  output logic sda_oe_o,
  // register side
  input wire logic wr_ok_i,
  input wire logic [7:0] rd_data_i,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o
);
  import arpf_pkg::*;

  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_ACK_A, T_SUB, T_ACK_S, T_WDATA, T_ACK_W,
    T_RDATA, T_ACK_R
  } arpf_tst_e;

  typedef struct packed {
    arpf_tst_e st;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [7:0] sub;
    logic rw;
    logic nack;
    logic scl_q;
    logic sda_q;
    logic oe;
    logic wr_en;
    logic [7:0] wr_data;
  } arpf_tgt_s;

  arpf_tgt_s s;
  arpf_tgt_s next_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign rise = scl_i & ~s.scl_q;
  assign fall = ~scl_i & s.scl_q;
  assign start = s.scl_q & scl_i & s.sda_q & ~sda_i;
  assign stop = s.scl_q & scl_i & ~s.sda_q & sda_i;

  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    next_s.scl_q = scl_i;
    next_s.sda_q = sda_i;
    if (!rst_b_i) begin
      next_s = '0;
      next_s.st = T_IDLE;
      next_s.scl_q = 1'b1;
      next_s.sda_q = 1'b1;
    end else if (start) begin
      next_s.st = T_ADDR;
      next_s.bitc = 4'h0;
      next_s.oe = 1'b0;
    end else if (stop) begin
      next_s.st = T_IDLE;
      next_s.oe = 1'b0;
    end else begin
      case (s.st)
        T_ADDR, T_SUB, T_WDATA: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], sda_i};
            next_s.bitc = s.bitc + 4'h1;
          end else if (fall && s.bitc == 4'h8) begin
            next_s.bitc = 4'h0;
            if (s.st == T_ADDR) begin
              if (s.sh[7:1] == dev_addr(addr_sel_i)) begin
                next_s.rw = s.sh[0];
                next_s.oe = 1'b1;
                next_s.st = T_ACK_A;
              end else begin
                next_s.st = T_IDLE;
              end
            end else if (s.st == T_SUB) begin
              next_s.sub = s.sh;
              next_s.oe = 1'b1;
              next_s.st = T_ACK_S;
            end else begin
              next_s.nack = ~wr_ok_i;
              next_s.wr_en = wr_ok_i;
              next_s.wr_data = s.sh;
              next_s.oe = wr_ok_i;
              next_s.st = T_ACK_W;
            end
          end
        end
        T_ACK_A: begin
          if (fall) begin
            if (s.rw) begin
              next_s.st = T_RDATA;
              next_s.sh = rd_data_i;
              next_s.oe = ~rd_data_i[7];
            end else begin
              next_s.st = T_SUB;
              next_s.oe = 1'b0;
            end
          end
        end
        T_ACK_S: begin
          if (fall) begin
            next_s.st = T_WDATA;
            next_s.oe = 1'b0;
          end
        end
        T_ACK_W: begin
          if (fall) begin
            next_s.oe = 1'b0;
            next_s.st = T_WDATA;
            if (!s.nack) begin
              next_s.sub = s.sub + 8'h01;
            end
          end
        end
        T_RDATA: begin
          if (rise) begin
            next_s.bitc = s.bitc + 4'h1;
          end else if (fall) begin
            if (s.bitc == 4'h8) begin
              next_s.oe = 1'b0;
              next_s.bitc = 4'h0;
              next_s.st = T_ACK_R;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.oe = ~s.sh[6];
            end
          end
        end
        T_ACK_R: begin
          if (rise) begin
            next_s.nack = sda_i;
            next_s.sub = s.sub + 8'h01;
          end else if (fall) begin
            if (s.nack) begin
              next_s.st = T_IDLE;
            end else begin
              next_s.st = T_RDATA;
              next_s.sh = rd_data_i;
              next_s.oe = ~rd_data_i[7];
            end
          end
        end
        default: begin
          next_s.st = T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign sda_oe_o = s.oe;
  assign wr_en_o = s.wr_en;
  assign wr_addr_o = s.sub;
  assign wr_data_o = s.wr_data;
  assign rd_addr_o = s.sub;
endmodule

// [core/arpf_host.sv]
// host controller end: bus master for register transfers and control pins
`timescale 1ns/1ns
module arpf_host #(
  parameter logic ADDR_SEL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // link to device
  arpf_if.host bus,
  // pin requests
  input wire logic reset_req_i,
  input wire logic pwr_down_req_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] cmd_sub_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  // answer port
  output logic rsp_valid_o,
  output logic rsp_nack_o,
  output logic [7:0] rsp_data_o,
  output logic fault_o
);
  import arpf_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} arpf_hst_e;

  typedef struct packed {
    arpf_hst_e st;
    logic [1:0] q;
    logic [5:0] tcnt;
    logic [2:0] idx;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rd;
    logic [7:0] sub;
    logic [7:0] data;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic rsp_valid;
    logic rsp_nack;
    logic [7:0] rsp_data;
    logic fault;
    logic rst_pin;
    logic pd_pin;
  } arpf_host_s;

  arpf_host_s s;
  arpf_host_s next_s;

  function automatic logic [7:0] byte_of(input logic [2:0] idx,
                                         input logic [7:0] sub,
                                         input logic [7:0] data);
    case (idx)
      3'h0: byte_of = {dev_addr(ADDR_SEL), 1'b0};
      3'h1: byte_of = sub;
      3'h2: byte_of = data;
      3'h3: byte_of = {dev_addr(ADDR_SEL), 1'b1};
      default: byte_of = 8'hff;
    endcase
  endfunction

  always_comb begin
    logic tick;
    logic rx;
    tick = s.tcnt == 6'(SCL_QTR_CYC - 1);
    rx = s.idx == 3'h4;
    next_s = s;
    next_s.rsp_valid = 1'b0;
    next_s.tcnt = tick ? 6'h00 : s.tcnt + 6'h01;
    next_s.fault = ~bus.fault_out;
    next_s.rst_pin = ~reset_req_i;
    next_s.pd_pin = ~pwr_down_req_i;
    if (!rst_b_i) begin
      next_s = '0;
      next_s.st = H_IDLE;
      next_s.ready = 1'b1;
      next_s.pd_pin = 1'b1;
    end else begin
      case (s.st)
        H_IDLE: begin
          if (cmd_valid_i && s.ready) begin
            next_s.ready = 1'b0;
            next_s.rd = cmd_read_i;
            next_s.sub = cmd_sub_i;
            next_s.data = cmd_data_i;
            next_s.idx = 3'h0;
            next_s.nack = 1'b0;
            next_s.q = 2'h0;
            next_s.st = H_START;
          end
        end
        H_START: begin
          if (tick) begin
            next_s.q = s.q + 2'h1;
            case (s.q)
              2'h0: begin
                next_s.scl_oe = 1'b1;
                next_s.sda_oe = 1'b0;
              end
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b1;
              default: begin
                next_s.scl_oe = 1'b1;
                next_s.st = H_BIT;
                next_s.bitc = 4'h0;
                next_s.sh = byte_of(s.idx, s.sub, s.data);
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            next_s.q = s.q + 2'h1;
            case (s.q)
              2'h0: next_s.sda_oe = (s.bitc < 4'h8 && !rx) ? ~s.sh[7]
                                                          : 1'b0;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: begin
                if (s.bitc < 4'h8) begin
                  next_s.sh = {s.sh[6:0], bus.sda};
                end else if (!rx) begin
                  next_s.nack = s.nack | bus.sda;
                end
              end
              default: begin
                next_s.scl_oe = 1'b1;
                if (s.bitc != 4'h8) begin
                  next_s.bitc = s.bitc + 4'h1;
                end else if (rx || s.nack || s.idx == 3'h2) begin
                  next_s.st = H_STOP;
                end else if (s.idx == 3'h1 && s.rd) begin
                  next_s.idx = 3'h3;
                  next_s.st = H_START;
                end else begin
                  next_s.idx = s.idx + 3'h1;
                  next_s.bitc = 4'h0;
                  next_s.sh = byte_of(s.idx + 3'h1, s.sub, s.data);
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            next_s.q = s.q + 2'h1;
            case (s.q)
              2'h0: next_s.sda_oe = 1'b1;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b0;
              default: begin
                next_s.st = H_IDLE;
                next_s.ready = 1'b1;
                next_s.rsp_valid = 1'b1;
                next_s.rsp_nack = s.nack;
                next_s.rsp_data = rx ? s.sh : 8'h00;
              end
            endcase
          end
        end
        default: begin
          next_s.st = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign bus.scl_oe = s.scl_oe;
  assign bus.host_sda_oe = s.sda_oe;
  assign bus.hw_reset_in = s.rst_pin;
  assign bus.power_down_in = s.pd_pin;
  assign cmd_ready_o = s.ready;
  assign rsp_valid_o = s.rsp_valid;
  assign rsp_nack_o = s.rsp_nack;
  assign rsp_data_o = s.rsp_data;
  assign fault_o = s.fault;
endmodule

// [testbench/arpf_props.sv]
// link assertions for the amplifier control two-wire bus
`timescale 1ns/1ns
module arpf_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic fault_oe,
  input wire logic hw_reset_in,
  // address strap seen by the device
  input wire logic addr_sel
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bits;
  logic [7:0] sh;
  logic [6:0] own;
  assign own = {4'h6, addr_sel, 2'h0};
  // ****
  // bit slots since the last start
  // ****
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_b_i) begin
      bits <= 4'hf;
    end else if (scl_q && scl && sda_q && !sda) begin
      bits <= 4'h0;
    end else if (!scl_q && scl && bits != 4'hf) begin
      bits <= bits + 4'h1;
    end
    if (!scl_q && scl) begin
      sh <= {sh[6:0], sda};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_addr_quiet: assert property (bits < 4'h8 |-> !dev_sda_oe)
    else $error("sda driven in address bits");
  a_ack_match: assert property (hw_reset_in && bits == 4'h8
    && $fell(scl) && sh[7:1] == own |-> ##[1:2] dev_sda_oe)
    else $error("own address not acknowledged");
  a_ack_miss: assert property (bits == 4'h8 && $fell(scl)
    && sh[7:1] != own |-> ##1 !dev_sda_oe [*2])
    else $error("foreign address acknowledged");
  a_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("sda taken while clock high");
  a_hold_scl_high: assert property (scl && $past(scl)
    |-> $stable(dev_sda_oe))
    else $error("sda moved while clock high");
  a_reset_free_sda: assert property (!hw_reset_in |=> !dev_sda_oe)
    else $error("sda driven in reset");
  a_reset_fault: assert property (!hw_reset_in ##1 !hw_reset_in
    |-> !fault_oe)
    else $error("fault kept through reset");
  a_fault_held: assert property ($rose(fault_oe) |=> fault_oe [*8])
    else $error("fault not latched");
endmodule

// [testbench/amp_reset_power_fault_ctrl_test.sv]
// self-checking bench joining host and amplifier control ends
`timescale 1ns/1ns
module amp_reset_power_fault_ctrl_test;
  import arpf_pkg::*;
  logic clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic rq = 1'h0, pq = 1'h0, cv = 1'h0, cr = 1'h0, sel = 1'h0;
  logic hot = 1'h0, cool = 1'h1, low = 1'h0, ok = 1'h1, sc = 1'h0;
  logic [7:0] cs = 8'h00, cd = 8'h00;
  logic rdy, rv, nack, flt, stg, dclk, bias, run, inr, ctk, ftk, mm;
  logic [7:0] rdat, vol;
  logic [2:0] chm;
  int n_errors = 0;
  int total_checks = 0;
  arpf_if arpf_if_inst ();
  wire logic [8:0] mon = {arpf_if_inst.hw_reset_in, rdy, vol === 8'h40,
                          flt, ftk, ctk, inr, stg, rv};
  arpf_host #(.ADDR_SEL(1'h0)) arpf_host_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .bus(arpf_if_inst.host), .reset_req_i(rq),
    .pwr_down_req_i(pq), .cmd_valid_i(cv), .cmd_read_i(cr), .cmd_sub_i(cs),
    .cmd_data_i(cd), .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_nack_o(nack),
    .rsp_data_o(rdat), .fault_o(flt));
  arpf_device arpf_device_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus(arpf_if_inst.device), .addr_sel_i(sel), .temp_hot_i(hot),
    .temp_cool_i(cool), .short_det_i(sc), .supply_low_i(low),
    .supply_ok_i(ok), .out_stage_en_o(stg), .dig_clk_en_o(dclk),
    .analog_bias_en_o(bias), .proc_run_o(run), .in_reset_o(inr),
    .carrier_tick_o(ctk), .frame_tick_o(ftk), .volume_o(vol),
    .master_mute_o(mm), .ch_mute_o(chm));
  arpf_props arpf_props_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .scl(arpf_if_inst.scl), .sda(arpf_if_inst.sda),
    .dev_sda_oe(arpf_if_inst.dev_sda_oe), .fault_oe(arpf_if_inst.fault_oe),
    .hw_reset_in(arpf_if_inst.hw_reset_in), .addr_sel(sel));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wt(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      #1;
      if (mon[s] === v) break;
    end
    if (i == lim) begin
      chk(32'h1, 32'h0);
      report_and_stop();
    end
  endtask
  task automatic xfer(input logic rd, input logic [7:0] s, logic [7:0] d);
    wt(7, 1'h1, 100);
    @(posedge clk_i);
    cv <= 1'h1;
    cr <= rd;
    cs <= s;
    cd <= d;
    @(posedge clk_i);
    cv <= 1'h0;
    wt(0, 1'h1, 12000);
    @(posedge clk_i);
  endtask
  task automatic gap(input int s, input int exp);
    int n;
    wt(s, 1'h1, 2100);
    for (n = 1; n < 2100; n++) begin
      @(posedge clk_i);
      #1;
      if (mon[s] === 1'h1) break;
    end
    chk(n, exp);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset(input logic pulse);
    int n;
    if (pulse) begin
      @(posedge clk_i);
      rq <= 1'h1;
      repeat (3) @(posedge clk_i);
      rq <= 1'h0;
    end
    wt(8, 1'h1, 10);
    for (n = 0; n < 300; n++) begin
      @(posedge clk_i);
      #1;
      if (n > 4 && inr === 1'h0) break;
    end
    chk(n >= 255 && n <= 259, 1'h1);
    chk({vol, mm, chm, flt}, {VOL_NEG_INF, 4'hf, 1'h0});
    $display("reset test done");
  endtask
  task automatic t_regs();
    xfer(1'h0, REG_SC3, 8'h05);
    chk({nack, mm, chm}, 5'h05);
    xfer(1'h0, REG_MVOL, 8'h40);
    xfer(1'h1, REG_MVOL, 8'h00);
    chk({nack, rdat}, 9'h040);
    sel <= 1'h1;
    xfer(1'h0, REG_MVOL, 8'h22);
    chk(nack, 1'h1);
    sel <= 1'h0;
    xfer(1'h0, REG_SC2, 8'h10);
    gap(4, RATIO_FS96);
    $display("register test done");
  endtask
  task automatic t_pd();
    @(posedge clk_i);
    pq <= 1'h1;
    repeat (4) wt(4, 1'h1, 1100);
    chk({stg, vol !== 8'h40}, 2'h3);
    @(posedge clk_i);
    pq <= 1'h0;
    wt(6, 1'h1, 20000);
    chk({stg, bias, dclk}, 3'h7);
    @(posedge clk_i);
    pq <= 1'h1;
    wt(1, 1'h0, 20000);
    chk({dclk, bias, vol}, {2'h0, VOL_NEG_INF});
    xfer(1'h0, REG_MVOL, 8'h11);
    chk(nack, 1'h1);
    pq <= 1'h0;
    wt(1, 1'h1, 20000);
    xfer(1'h1, REG_MVOL, 8'h00);
    chk(rdat, 8'h40);
    $display("power-down test done");
  endtask
  task automatic t_prot();
    @(posedge clk_i);
    cool <= 1'h0;
    hot <= 1'h1;
    wt(5, 1'h1, 20);
    chk(stg, 1'h0);
    @(posedge clk_i);
    hot <= 1'h0;
    cool <= 1'h1;
    repeat (20) @(posedge clk_i);
    #1;
    chk(flt, 1'h1);
    @(posedge clk_i);
    pq <= 1'h1;
    wt(5, 1'h0, 30);
    @(posedge clk_i);
    pq <= 1'h0;
    wt(1, 1'h1, 20000);
    @(posedge clk_i);
    ok <= 1'h0;
    low <= 1'h1;
    wt(1, 1'h0, 20);
    chk(run, 1'h0);
    @(posedge clk_i);
    low <= 1'h0;
    ok <= 1'h1;
    wt(1, 1'h1, 20000);
    chk(run, 1'h1);
    @(posedge clk_i);
    sc <= 1'h1;
    wt(5, 1'h1, 20);
    @(posedge clk_i);
    sc <= 1'h0;
    repeat (8) @(posedge clk_i);
    #1;
    chk({flt, stg}, 2'h2);
    xfer(1'h0, REG_SC3, 8'h08);
    chk(flt, 1'h0);
    $display("protection test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_reset(1'h0);
    gap(3, CARRIER_DIV);
    gap(4, RATIO_FS48);
    t_regs();
    t_pd();
    t_prot();
    t_reset(1'h1);
    report_and_stop();
  end
endmodule
